// ---- common/thermo_pkg.sv ----
// shared constants for the thermometer scratchpad, identifier and alarm block
`default_nettype none
package thermo_pkg;
  // scratchpad byte addresses
  localparam logic [2:0] ADDR_TEMP_LO = 3'h0;
  localparam logic [2:0] ADDR_TEMP_HI = 3'h1;
  localparam logic [2:0] ADDR_UPPER = 3'h2;
  localparam logic [2:0] ADDR_LOWER = 3'h3;
  localparam logic [2:0] ADDR_CONFIG = 3'h4;
  localparam logic [2:0] ADDR_RSV0 = 3'h5;
  localparam logic [2:0] ADDR_RSV1 = 3'h6;
  // reserved byte contents, constant
  localparam logic [7:0] RSV0_VALUE = 8'hFF;
  localparam logic [7:0] RSV1_VALUE = 8'h00;
  localparam logic [7:0] RSV2_VALUE = 8'h10;
  // reset values
  localparam logic [15:0] TEMP_RESET = 16'h0550;
  localparam logic [7:0] NV_UPPER_DEFAULT = 8'h55;
  localparam logic [7:0] NV_LOWER_DEFAULT = 8'h00;
  localparam logic [7:0] NV_CONFIG_DEFAULT = 8'h7F;
  // configuration field layout
  localparam int CFG_RES_MSB = 6;
  localparam int CFG_RES_LSB = 5;
  localparam logic [7:0] CFG_RES_MASK = 8'h60;
  localparam logic [7:0] CFG_FIXED_ONES = 8'h1F;
  // resolution codes and readout masks
  localparam logic [1:0] RES_9 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_11 = 2'h2;
  localparam logic [15:0] MASK_9 = 16'hFFF8;
  localparam logic [15:0] MASK_10 = 16'hFFFC;
  localparam logic [15:0] MASK_11 = 16'hFFFE;
  localparam logic [15:0] MASK_12 = 16'hFFFF;
  // integer-degree slice of the readout
  localparam int TEMP_INT_MSB = 11;
  localparam int TEMP_INT_LSB = 4;
  // identifier CRC
  localparam logic [7:0] CRC_POLY_REFL = 8'h8C;
  localparam logic [5:0] ID_DATA_LAST = 6'h37;
  localparam logic [5:0] CRC_LAST = 6'h07;
  // network-level command codes
  localparam logic [2:0] NET_READ = 3'h0;
  localparam logic [2:0] NET_MATCH = 3'h1;
  localparam logic [2:0] NET_SEARCH = 3'h2;
  localparam logic [2:0] NET_ALARM_SEARCH = 3'h3;
  localparam logic [2:0] NET_COND_READ = 3'h4;
  localparam logic [2:0] NET_SKIP = 3'h5;
  localparam logic [2:0] NET_OD_SKIP = 3'h6;
  localparam logic [2:0] NET_OD_MATCH = 3'h7;
  // identifier start-up phases
  typedef enum logic [3:0] {
    PH_LOAD = 4'h1,
    PH_CALC = 4'h2,
    PH_CHECK = 4'h4,
    PH_IDLE = 4'h8
  } phase_t;
endpackage
`default_nettype wire

// ---- rtl/thermometer_scratchpad_alarm.sv ----
// scratchpad, identifier CRC, readout and alarm logic of the thermometer
`default_nettype none
module thermometer_scratchpad_alarm #(
  parameter logic [7:0] FAMILY_CODE = 8'h5A,         // arbitrary value
  parameter logic [47:0] SERIAL_NUMBER = 48'h0123456789AB // arbitrary value
) (
  input wire logic clock,              // 50 MHz system clock
  input wire logic arst_n,             // asynchronous reset, active low
  input wire logic bus_reset,          // pulse: bus reset seen
  input wire logic rom_cmd_done,       // pulse: network command executed
  input wire logic [2:0] rom_cmd,      // code of that network command
  input wire logic dev_cmd_valid,      // pulse: device command offered
  input wire logic wr_en,              // pulse: scratchpad byte write
  input wire logic [2:0] wr_addr,      // byte address of the write
  input wire logic [7:0] wr_data,      // write data
  input wire logic copy_req,           // pulse: copy to backup storage
  input wire logic rd_en,              // pulse: scratchpad read
  input wire logic [5:0] rd_index,     // bit index, byte in [5:3]
  input wire logic conv_done,          // pulse: conversion finished
  input wire logic [15:0] conv_result, // full 12-bit conversion result
  input wire logic vdd_pin,            // supply detector pin, async
  output logic rd_valid,               // pulse: read answer valid
  output logic [7:0] rd_byte,          // addressed byte
  output logic rd_bit,                 // addressed bit, lsb first
  output logic [63:0] id_number,       // registration number
  output logic id_valid,               // identifier crc checked good
  output logic alarm_flag,             // alarm condition / search join
  output logic overdrive,              // overdrive speed selected
  output logic dev_cmd_enabled,        // device commands allowed
  output logic dev_cmd_taken,          // pulse: device command accepted
  output logic local_power,            // local supply present
  output logic [1:0] resolution_select // configured resolution
);
  // whole state of the block
  typedef struct packed {
    logic [15:0] temp;      // readout bytes 0 and 1
    logic [7:0] upper;      // upper threshold byte
    logic [7:0] lower;      // lower threshold byte
    logic [7:0] cfg;        // configuration byte
    logic [7:0] nv_upper;   // backup copies
    logic [7:0] nv_lower;
    logic [7:0] nv_cfg;
    logic alarm;            // alarm condition
    logic od;               // overdrive mode
    logic rom_ok;           // network command done
    logic cmd_taken;        // device command accepted
    logic rd_valid;         // read answer strobe
    logic [7:0] rd_byte;    // read answer byte
    logic rd_bit;           // read answer bit
    thermo_pkg::phase_t phase; // identifier start-up phase
    logic [5:0] cnt;        // crc bit counter
    logic [7:0] crc;        // crc shift register
    logic [7:0] id_crc;     // computed identifier crc
    logic [63:0] id;        // registration number
    logic id_ok;            // identifier checked
    logic [2:0] vsync;      // supply pin synchroniser
    logic lpwr;             // filtered supply state
  } state_t;

  localparam state_t RESET_STATE = '{
    temp: thermo_pkg::TEMP_RESET,
    upper: thermo_pkg::NV_UPPER_DEFAULT,
    lower: thermo_pkg::NV_LOWER_DEFAULT,
    cfg: thermo_pkg::NV_CONFIG_DEFAULT,
    nv_upper: thermo_pkg::NV_UPPER_DEFAULT,
    nv_lower: thermo_pkg::NV_LOWER_DEFAULT,
    nv_cfg: thermo_pkg::NV_CONFIG_DEFAULT,
    phase: thermo_pkg::PH_LOAD,
    default: '0
  };

  state_t st;      // registered state
  state_t next_st; // next state

  // identifier data in shift order
  logic [55:0] id_data;
  assign id_data = {SERIAL_NUMBER, FAMILY_CODE};

  // conversion result, crc and read mux helpers
  logic [15:0] res_mask;       // resolution mask
  logic [15:0] masked;         // result with undefined bits zeroed
  logic signed [7:0] res_int;  // integer-degree part
  logic hi_hit;                // at or above upper
  logic lo_hit;                // at or below lower
  logic crc_in;                // bit shifted into crc
  logic crc_fb;                // crc feedback
  logic [7:0] crc_next;        // crc after one shift
  logic [7:0] sel_byte;        // scratchpad byte at read address

  // resolution mask from configuration bits 6:5
  always_comb begin
    case (st.cfg[thermo_pkg::CFG_RES_MSB:thermo_pkg::CFG_RES_LSB])
      thermo_pkg::RES_9: res_mask = thermo_pkg::MASK_9;
      thermo_pkg::RES_10: res_mask = thermo_pkg::MASK_10;
      thermo_pkg::RES_11: res_mask = thermo_pkg::MASK_11;
      default: res_mask = thermo_pkg::MASK_12;
    endcase
  end

  // threshold compare on whole degrees
  always_comb begin
    masked = conv_result & res_mask;
    res_int = $signed(masked[thermo_pkg::TEMP_INT_MSB:thermo_pkg::TEMP_INT_LSB]);
    hi_hit = res_int >= $signed(st.upper);
    lo_hit = res_int <= $signed(st.lower);
  end

  // one step of the reflected crc generator
  always_comb begin
    if (st.phase == thermo_pkg::PH_CHECK) begin
      crc_in = st.id_crc[st.cnt[2:0]];
    end else begin
      crc_in = id_data[st.cnt];
    end
    crc_fb = st.crc[0] ^ crc_in;
    crc_next = {1'b0, st.crc[7:1]} ^ (crc_fb ? thermo_pkg::CRC_POLY_REFL : 8'h00);
  end

  // scratchpad read mux
  always_comb begin
    case (rd_index[5:3])
      thermo_pkg::ADDR_TEMP_LO: sel_byte = st.temp[7:0];
      thermo_pkg::ADDR_TEMP_HI: sel_byte = st.temp[15:8];
      thermo_pkg::ADDR_UPPER: sel_byte = st.upper;
      thermo_pkg::ADDR_LOWER: sel_byte = st.lower;
      thermo_pkg::ADDR_CONFIG: sel_byte = st.cfg;
      thermo_pkg::ADDR_RSV0: sel_byte = thermo_pkg::RSV0_VALUE;
      thermo_pkg::ADDR_RSV1: sel_byte = thermo_pkg::RSV1_VALUE;
      default: sel_byte = thermo_pkg::RSV2_VALUE;
    endcase
  end

  // next-state logic
  always_comb begin
    next_st = st;
    next_st.cmd_taken = 1'b0;
    next_st.rd_valid = 1'b0;
    // identifier start-up sequence and power-up recall
    case (st.phase)
      thermo_pkg::PH_LOAD: begin
        next_st.upper = st.nv_upper;
        next_st.lower = st.nv_lower;
        next_st.cfg = st.nv_cfg;
        next_st.crc = 8'h00;
        next_st.cnt = 6'h00;
        next_st.phase = thermo_pkg::PH_CALC;
      end
      thermo_pkg::PH_CALC: begin
        next_st.crc = crc_next;
        next_st.cnt = st.cnt + 6'h01;
        if (st.cnt == thermo_pkg::ID_DATA_LAST) begin
          next_st.id_crc = crc_next;
          next_st.cnt = 6'h00;
          next_st.phase = thermo_pkg::PH_CHECK;
        end
      end
      thermo_pkg::PH_CHECK: begin
        next_st.crc = crc_next;
        next_st.cnt = st.cnt + 6'h01;
        if (st.cnt == thermo_pkg::CRC_LAST) begin
          next_st.id = {st.id_crc, id_data};
          next_st.id_ok = (crc_next == 8'h00);
          next_st.phase = thermo_pkg::PH_IDLE;
        end
      end
      thermo_pkg::PH_IDLE: begin
        next_st.phase = thermo_pkg::PH_IDLE;
      end
      default: begin
        next_st.phase = thermo_pkg::PH_LOAD;
      end
    endcase
    // network level: bus reset drops access, a completed command grants it
    if (bus_reset) begin
      next_st.rom_ok = 1'b0;
    end
    if (rom_cmd_done) begin
      next_st.rom_ok = 1'b1;
      if (!st.od && (rom_cmd == thermo_pkg::NET_OD_SKIP ||
                     rom_cmd == thermo_pkg::NET_OD_MATCH)) begin
        next_st.od = 1'b1;
      end
    end
    // device-level commands only while access is granted
    if (dev_cmd_valid && st.rom_ok) begin
      next_st.cmd_taken = 1'b1;
    end
    if (wr_en && st.rom_ok) begin
      case (wr_addr)
        thermo_pkg::ADDR_UPPER: next_st.upper = wr_data;
        thermo_pkg::ADDR_LOWER: next_st.lower = wr_data;
        thermo_pkg::ADDR_CONFIG: begin
          next_st.cfg = (wr_data & thermo_pkg::CFG_RES_MASK) | thermo_pkg::CFG_FIXED_ONES;
        end
        default: begin
          next_st.cfg = st.cfg; // readout and reserved bytes ignore writes
        end
      endcase
    end
    if (copy_req && st.rom_ok) begin
      next_st.nv_upper = st.upper;
      next_st.nv_lower = st.lower;
      next_st.nv_cfg = st.cfg;
    end
    if (rd_en && st.rom_ok) begin
      next_st.rd_valid = 1'b1;
      next_st.rd_byte = sel_byte;
      next_st.rd_bit = sel_byte[rd_index[2:0]];
    end
    // conversion result updates readout and alarm
    if (conv_done) begin
      next_st.temp = masked;
      // set at or beyond a threshold, cleared only strictly inside both
      next_st.alarm = hi_hit || lo_hit;
    end
    // supply detector: three stages, accept when last two agree
    next_st.vsync = {st.vsync[1:0], vdd_pin};
    if (st.vsync[1] == st.vsync[2]) begin
      next_st.lpwr = st.vsync[2];
    end
  end

  // state register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st <= RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign rd_valid = st.rd_valid;
  assign rd_byte = st.rd_byte;
  assign rd_bit = st.rd_bit;
  assign id_number = st.id;
  assign id_valid = st.id_ok;
  assign alarm_flag = st.alarm;
  assign overdrive = st.od;
  assign dev_cmd_enabled = st.rom_ok;
  assign dev_cmd_taken = st.cmd_taken;
  assign local_power = st.lpwr;
  assign resolution_select = st.cfg[thermo_pkg::CFG_RES_MSB:thermo_pkg::CFG_RES_LSB];

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // boot: load, 56 data shifts, 8 crc shifts, then valid
  sequence s_boot;
    (st.phase == thermo_pkg::PH_LOAD) ##1 (st.phase == thermo_pkg::PH_CALC) [*8];
  endsequence
  sequence s_hi_conv;
    conv_done && hi_hit;
  endsequence
  sequence s_lo_conv;
    conv_done && lo_hit;
  endsequence
  sequence s_mid_conv;
    conv_done && !hi_hit && !lo_hit;
  endsequence

  a_boot_id_ready: assert property (s_boot |-> ##57 id_valid)
    else $error("identifier not validated after crc check");
  a_boot_recall: assert property ((st.phase == thermo_pkg::PH_LOAD) |=>
      st.upper == $past(st.nv_upper) && st.cfg == $past(st.nv_cfg))
    else $error("thresholds not recalled at power-up");
  a_readout_update: assert property (conv_done |=> st.temp == $past(masked))
    else $error("readout not loaded from conversion");
  a_readout_only_conv: assert property (!conv_done |=> $stable(st.temp))
    else $error("readout changed without conversion");
  // alarm must survive one more cycle unless a new conversion came in between
  a_alarm_set_hi: assert property (s_hi_conv |=>
      alarm_flag ##1 (alarm_flag || $past(conv_done)))
    else $error("alarm not raised at upper threshold");
  a_alarm_set_lo: assert property (s_lo_conv |=> alarm_flag)
    else $error("alarm not raised at lower threshold");
  a_alarm_clear_mid: assert property (s_mid_conv |=> !alarm_flag)
    else $error("alarm not cleared between thresholds");
  a_alarm_hold: assert property (!conv_done |=> $stable(alarm_flag))
    else $error("alarm changed without conversion");
  a_od_switch: assert property (rom_cmd_done && rom_cmd == thermo_pkg::NET_OD_SKIP
      |=> overdrive)
    else $error("overdrive not entered");
  a_cmd_gate: assert property (dev_cmd_taken |-> $past(dev_cmd_enabled) && $past(dev_cmd_valid))
    else $error("device command accepted without network command");
  a_cfg_fixed: assert property (st.phase == thermo_pkg::PH_IDLE |->
      st.cfg[7] == 1'b0 && st.cfg[4:0] == 5'h1F)
    else $error("fixed configuration bits altered");
  a_nv_copy: assert property (copy_req && dev_cmd_enabled |=>
      st.nv_lower == $past(st.lower) && st.nv_upper == $past(st.upper))
    else $error("copy to backup failed");
  a_low_bits: assert property (conv_done && resolution_select == thermo_pkg::RES_9
      |=> st.temp[2:0] == 3'h0)
    else $error("undefined low bits not cleared at 9-bit");

  // network access: a bus reset alone withdraws device-level access
  a_bus_reset_drop: assert property (bus_reset && !rom_cmd_done |=> !dev_cmd_enabled)
    else $error("access kept after bus reset");
  // read answers: addressed byte one cycle after an accepted read
  a_read_answer: assert property (rd_en && dev_cmd_enabled |=>
      rd_valid && rd_byte == $past(sel_byte))
    else $error("read not answered with addressed byte");
  a_read_refused: assert property (!(rd_en && dev_cmd_enabled) |=> !rd_valid)
    else $error("read answered without access");
  // supply filter: no change while the last two stages disagree
  a_supply_hold: assert property (st.vsync[2] != st.vsync[1] |=> $stable(local_power))
    else $error("supply state changed before pin settled");
endmodule
`default_nettype wire

// ---- test/master_model.sv ----
// bus master model issuing network, device and scratchpad requests
`default_nettype none
module master_model (
  input wire logic clock,        // system clock
  output logic bus_reset,        // bus reset pulse
  output logic rom_cmd_done,     // network command pulse
  output logic [2:0] rom_cmd,    // network command code
  output logic dev_cmd_valid,    // device command pulse
  output logic wr_en,            // byte write pulse
  output logic [2:0] wr_addr,    // write address
  output logic [7:0] wr_data,    // write data
  output logic copy_req,         // copy pulse
  output logic rd_en,            // read pulse
  output logic [5:0] rd_index,   // bit index
  input wire logic rd_valid,     // read answer strobe
  input wire logic rd_bit        // read answer bit
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle state at time zero
  initial begin
    {bus_reset, rom_cmd_done, dev_cmd_valid, wr_en, copy_req, rd_en} = 6'h00;
    {rom_cmd, wr_addr, wr_data, rd_index} = 20'h00000;
  end
  // bus reset, then optionally one network command
  task automatic net_cmd(input logic [2:0] code, input logic send);
    @(negedge clock);
    bus_reset = 1'b1;
    @(negedge clock);
    bus_reset = 1'b0;
    rom_cmd_done = send;
    rom_cmd = code;
    @(negedge clock);
    rom_cmd_done = 1'b0;
    rom_cmd = ~code; // released lines do not keep the old value
  endtask
  // one byte write
  task automatic write(input logic [2:0] a, input logic [7:0] d);
    @(negedge clock);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clock);
    wr_en = 1'b0;
    wr_addr = ~a;
    wr_data = ~d;
  endtask
  // device command, with copy request if asked
  task automatic dev_cmd(input logic cp);
    @(negedge clock);
    dev_cmd_valid = 1'b1;
    copy_req = cp;
    @(negedge clock);
    dev_cmd_valid = 1'b0;
    copy_req = 1'b0;
  endtask
  // serial byte read, bit by bit, bounded wait per bit
  task automatic read(input logic [2:0] a, output logic [7:0] d, output logic ok);
    int n;
    d = 8'h00;
    ok = 1'b1;
    for (int b = 0; b < 8; b++) begin
      @(negedge clock);
      rd_en = 1'b1;
      rd_index = {a, b[2:0]};
      n = 0;
      do begin
        @(negedge clock);
        rd_en = 1'b0;
        n++;
      end while (rd_valid !== 1'b1 && n < 3);
      if (rd_valid !== 1'b1) begin
        ok = 1'b0;
      end
      d[b] = rd_bit;
      rd_index = ~rd_index;
    end
  endtask
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench of the thermometer scratchpad and alarm block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] FAM = 8'h5A; // arbitrary value
  localparam logic [47:0] SER = 48'h0123456789AB; // arbitrary value
  logic clock, arst_n, conv_done, vdd_pin, bus_reset, rom_cmd_done, dev_cmd_valid;
  logic wr_en, copy_req, rd_en, rd_valid, rd_bit, id_valid, alarm_flag, overdrive;
  logic dev_cmd_enabled, dev_cmd_taken, local_power, ok;
  logic [2:0] rom_cmd, wr_addr;
  logic [7:0] wr_data, d, rd_byte;
  logic [5:0] rd_index;
  logic [15:0] conv_result;
  logic [63:0] id_number, exp_id;
  logic [1:0] resolution_select;
  logic [7:0] dflt [8];
  logic [15:0] temps [6];
  logic alarms [6];
  int bad_count = 0;
  int checks_done = 0;
  // clock generator, 20 ns
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  thermometer_scratchpad_alarm #(.FAMILY_CODE(FAM), .SERIAL_NUMBER(SER)) i_dut (
    .clock(clock), .arst_n(arst_n), .bus_reset(bus_reset), .rom_cmd_done(rom_cmd_done),
    .rom_cmd(rom_cmd), .dev_cmd_valid(dev_cmd_valid), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .copy_req(copy_req), .rd_en(rd_en), .rd_index(rd_index),
    .conv_done(conv_done), .conv_result(conv_result), .vdd_pin(vdd_pin),
    .rd_valid(rd_valid), .rd_byte(rd_byte), .rd_bit(rd_bit), .id_number(id_number),
    .id_valid(id_valid), .alarm_flag(alarm_flag), .overdrive(overdrive),
    .dev_cmd_enabled(dev_cmd_enabled), .dev_cmd_taken(dev_cmd_taken),
    .local_power(local_power), .resolution_select(resolution_select));
  master_model i_master (
    .clock(clock), .bus_reset(bus_reset), .rom_cmd_done(rom_cmd_done), .rom_cmd(rom_cmd),
    .dev_cmd_valid(dev_cmd_valid), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .copy_req(copy_req), .rd_en(rd_en), .rd_index(rd_index), .rd_valid(rd_valid),
    .rd_bit(rd_bit));
  // verdict and end of run
  task automatic conclude();
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // compare and report
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // read a byte and expect it answered or refused
  task automatic rd(input logic [2:0] a, input logic want, input logic [7:0] exp);
    i_master.read(a, d, ok);
    check("read answered", want, ok);
    if (want && ok !== 1'b1) begin
      conclude();
    end
    if (want) begin
      check("read byte", exp, d);
      check("parallel byte", exp, rd_byte);
    end
  endtask
  // conversion finished pulse
  task automatic conv(input logic [15:0] r);
    @(negedge clock);
    conv_done = 1'b1;
    conv_result = r;
    @(negedge clock);
    conv_done = 1'b0;
    conv_result = ~r;
  endtask
  // reference crc, bit serial, lsb first
  function automatic logic [7:0] crc8(input logic [63:0] v, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n; i++) begin
      c = (c >> 1) ^ ((c[0] ^ v[i]) ? 8'h8C : 8'h00);
    end
    return c;
  endfunction
  // main sequence
  initial begin
    {arst_n, conv_done, vdd_pin, conv_result} = 19'h00000;
    dflt = '{8'h50, 8'h05, 8'h55, 8'h00, 8'h7F, 8'hFF, 8'h00, 8'h10};
    temps = '{16'h0191, 16'h0100, 16'h00A2, 16'h00B0, 16'hFF5E, 16'h0190};
    alarms = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    repeat (8) @(negedge clock);
    arst_n = 1'b1;
    for (int i = 0; i < 100 && id_valid !== 1'b1; i++) @(negedge clock);
    check("id valid", 1'b1, id_valid);
    if (id_valid !== 1'b1) begin
      conclude();
    end
    exp_id = {crc8({8'h00, SER, FAM}, 56), SER, FAM};
    check("id number", exp_id, id_number);
    check("id residue", 8'h00, crc8(id_number, 64));
    rd(3'h0, 1'b0, 8'h00);
    i_master.dev_cmd(1'b0);
    check("cmd refused", 1'b0, dev_cmd_taken);
    for (int c = 0; c < 8; c++) begin
      i_master.net_cmd(c[2:0], 1'b1);
      check("enabled", 1'b1, dev_cmd_enabled);
      check("overdrive", c >= 6, overdrive);
    end
    i_master.dev_cmd(1'b0);
    check("cmd taken", 1'b1, dev_cmd_taken);
    i_master.write(3'h0, 8'hAA);
    i_master.write(3'h5, 8'h11);
    for (int a = 0; a < 8; a++) rd(a[2:0], 1'b1, dflt[a]);
    i_master.write(3'h2, 8'h19);
    i_master.write(3'h3, 8'h0A);
    for (int r = 0; r < 4; r++) begin
      i_master.write(3'h4, {1'b0, r[1:0], 5'h00});
      check("resolution", r[1:0], resolution_select);
      rd(3'h4, 1'b1, {1'b0, r[1:0], 5'h1F});
      conv(16'hF191);
      rd(3'h0, 1'b1, 8'h91 & (8'hFF << (3 - r)));
    end
    rd(3'h1, 1'b1, 8'hF1);
    for (int t = 0; t < 6; t++) begin
      conv(temps[t]);
      check("alarm", alarms[t], alarm_flag);
    end
    i_master.dev_cmd(1'b1);
    check("copy taken", 1'b1, dev_cmd_taken);
    check("local power", 1'b0, local_power);
    vdd_pin = 1'b1;
    for (int i = 0; i < 10 && local_power !== 1'b1; i++) @(negedge clock);
    check("local power", 1'b1, local_power);
    i_master.net_cmd(3'h5, 1'b0);
    check("bus reset", 1'b0, dev_cmd_enabled);
    rd(3'h2, 1'b0, 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
